/* core/counter_array.sv */
module counter_array #(
    parameter int MODULES = 5
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [counter_array_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // system
    input wire logic idle,
    input wire logic timer0Ovf,
    // port 1
    input wire logic [7:0] port1In,
    output logic [7:0] port1Out,
    // status
    output logic arrayIrq,
    output logic watchdogOn
);
    import counter_array_pkg::*;

    // the address map and interrupt mask are laid out for five modules
    if (MODULES != NMOD) begin
        $error("counter_array supports exactly five modules");
    end

    logic [7:0] arrayMode;
    logic [7:0] arrayCtrl;
    logic [7:0] modeReg [NMOD];
    logic [15:0] value [NMOD];
    logic [7:0] dutyLive [NMOD];
    logic [15:0] count;
    logic [NMOD-1:0] pinQ;
    logic [NMOD-1:0] pinOut;
    logic tick;
    logic run;
    logic [NMOD-1:0] hit;
    logic [NMOD-1:0] cap;
    logic ovf;
    logic lowWrap;
    logic step;
    logic [7:0] rdNext;
    logic [15:0] memRd;

    function automatic logic modeHit(input logic [4:0] a, input logic [4:0] b,
        input int n);
        return a == 5'(int'(b) + n);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // time base
    assign run = arrayCtrl[CB_RUN] && !(idle && arrayMode[MB_IDLE]);

    count_source u_src (
        .ref_clk(ref_clk),
        .rst(rst),
        .srcSel(arrayMode[MB_SRC+1:MB_SRC]),
        .run(run),
        .timer0Ovf(timer0Ovf),
        .extIn(port1In[EXT_PIN]),
        .tick(tick)
    );

    // the tick is one cycle late; a tick left over after a stop is dropped
    assign step = tick && run;
    assign ovf = step && (count == 16'hffff);
    assign lowWrap = step && (count[7:0] == 8'hff);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= 16'h0000;
        end else if (regWr && regAddr == ADDR_CNT_LO) begin
            count[7:0] <= regWrData;
        end else if (regWr && regAddr == ADDR_CNT_HI) begin
            count[15:8] <= regWrData;
        end else if (step) begin
            count <= count + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode and control registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arrayMode <= RESET_BYTE;
        end else if (regWr && regAddr == ADDR_MODE) begin
            arrayMode <= regWrData & MODE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            watchdogOn <= 1'b0;
        end else begin
            watchdogOn <= arrayMode[MB_WDOG] && modeReg[4][MM_CMP];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arrayCtrl <= RESET_BYTE;
        end else begin
            if (regWr && regAddr == ADDR_CTRL) begin
                arrayCtrl <= regWrData & CTRL_MASK;
            end
            if (ovf) begin
                arrayCtrl[CB_OVF] <= 1'b1;
            end
            for (int n = 0; n < NMOD; n++) begin
                if ((hit[n] && modeReg[n][MM_HIT]) || cap[n]) begin
                    arrayCtrl[n] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int n = 0; n < NMOD; n++) begin
                modeReg[n] <= RESET_BYTE;
            end
        end else begin
            for (int n = 0; n < NMOD; n++) begin
                if (regWr && modeHit(regAddr, ADDR_MMODE0, n)) begin
                    modeReg[n] <= regWrData & MMODE_MASK;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare, capture and pin logic
    always_comb begin
        for (int n = 0; n < NMOD; n++) begin
            hit[n] = step && modeReg[n][MM_CMP] && !modeReg[n][MM_PWM]
                && (count == value[n]);
            cap[n] = (modeReg[n][MM_RISE] && port1In[PIN_BASE+n]
                && !pinQ[n]) || (modeReg[n][MM_FALL]
                && !port1In[PIN_BASE+n] && pinQ[n]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinQ <= '1;
        end else begin
            for (int n = 0; n < NMOD; n++) begin
                pinQ[n] <= port1In[PIN_BASE+n];
            end
        end
    end

    // value registers: software write, capture, pwm reload
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int n = 0; n < NMOD; n++) begin
                value[n] <= 16'h0000;
                dutyLive[n] <= 8'h00;
            end
        end else begin
            for (int n = 0; n < NMOD; n++) begin
                if (cap[n]) begin
                    value[n] <= count;
                end else if (regWr && modeHit(regAddr, ADDR_VAL_LO0, n)) begin
                    value[n][7:0] <= regWrData;
                end else if (regWr && modeHit(regAddr, ADDR_VAL_HI0, n)) begin
                    value[n][15:8] <= regWrData;
                end
                if (lowWrap || !modeReg[n][MM_PWM]) begin
                    dutyLive[n] <= value[n][15:8];
                end
            end
        end
    end

    // pins idle high like a port latch; only output-mode modules drive low
    always_comb begin
        for (int n = 0; n < NMOD; n++) begin
            pinOut[n] = port1Out[PIN_BASE+n];
            if (modeReg[n][MM_PWM] && modeReg[n][MM_CMP]) begin
                pinOut[n] = count[7:0] >= dutyLive[n];
            end else if (hit[n] && modeReg[n][MM_FLIP]) begin
                pinOut[n] = !port1Out[PIN_BASE+n];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port1Out <= 8'hff;
        end else begin
            for (int n = 0; n < NMOD; n++) begin
                port1Out[PIN_BASE+n] <= pinOut[n];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arrayIrq <= 1'b0;
        end else begin
            arrayIrq <= (arrayCtrl[CB_OVF] && arrayMode[MB_OVIE])
                || |(arrayCtrl[NMOD-1:0] & {modeReg[4][MM_IE],
                modeReg[3][MM_IE], modeReg[2][MM_IE], modeReg[1][MM_IE],
                modeReg[0][MM_IE]});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port
    module_value_mem #(.DEPTH(NMOD)) u_mem (
        .ref_clk(ref_clk),
        .wrEn(1'b0),
        .wrIdx(3'h0),
        .wrData(16'h0000),
        .rdIdx(3'h0),
        .rdData(memRd)
    );

    always_comb begin
        rdNext = 8'h00;
        case (regAddr)
            ADDR_MODE: rdNext = arrayMode;
            ADDR_CTRL: rdNext = arrayCtrl;
            ADDR_CNT_LO: rdNext = count[7:0];
            ADDR_CNT_HI: rdNext = count[15:8];
            default: begin
                for (int n = 0; n < NMOD; n++) begin
                    if (modeHit(regAddr, ADDR_MMODE0, n)) begin
                        rdNext = modeReg[n];
                    end
                    if (modeHit(regAddr, ADDR_VAL_LO0, n)) begin
                        rdNext = modeReg[n][MM_PWM] ? dutyLive[n]
                            : value[n][7:0];
                    end
                    if (modeHit(regAddr, ADDR_VAL_HI0, n)) begin
                        rdNext = value[n][15:8];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            regRdData <= rdNext | (memRd[7:0] & 8'h00);
        end else begin
            regRdData <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_ovf_sets_flag: assert property (@(posedge ref_clk) disable iff (rst)
        ovf |=> arrayCtrl[CB_OVF])
        else $error("overflow did not set flag");
    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        arrayCtrl[CB_OVF] && !(regWr && regAddr == ADDR_CTRL)
        |=> arrayCtrl[CB_OVF])
        else $error("overflow flag cleared by hardware");
    a_stop_holds: assert property (@(posedge ref_clk) disable iff (rst)
        !arrayCtrl[CB_RUN] && !regWr |=> $stable(count))
        else $error("counter moved while stopped");
    a_idle_gate: assert property (@(posedge ref_clk) disable iff (rst)
        idle && arrayMode[MB_IDLE] && !regWr |=> $stable(count))
        else $error("counter moved in idle");
    a_capture_copy: assert property (@(posedge ref_clk) disable iff (rst)
        cap[3] |=> value[3] == $past(count) && arrayCtrl[3])
        else $error("capture lost");
    a_irq_follow: assert property (@(posedge ref_clk) disable iff (rst)
        arrayCtrl[CB_OVF] && arrayMode[MB_OVIE] |=> arrayIrq)
        else $error("interrupt missing");
    a_pwm_level: assert property (@(posedge ref_clk) disable iff (rst)
        modeReg[0][MM_PWM] && modeReg[0][MM_CMP]
        |=> port1Out[PIN_BASE] == ($past(count[7:0]) >= $past(dutyLive[0])))
        else $error("pwm level wrong");
    a_toggle_hit: assert property (@(posedge ref_clk) disable iff (rst)
        hit[1] && modeReg[1][MM_FLIP] |=> port1Out[PIN_BASE+1]
        != $past(port1Out[PIN_BASE+1]))
        else $error("toggle missing");
    // each property looks one edge past the state that triggers it
    a_hit_flag: assert property (@(posedge ref_clk) disable iff (rst)
        hit[1] && modeReg[1][MM_HIT] |=> arrayCtrl[1])
        else $error("compare hit did not set flag");
    a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
        step && !regWr |=> count == $past(count) + 16'h0001)
        else $error("counter did not step by one");
    a_duty_reload: assert property (@(posedge ref_clk) disable iff (rst)
        lowWrap && modeReg[0][MM_PWM] |=> dutyLive[0] == $past(value[0][15:8]))
        else $error("duty byte not reloaded");
    a_watchdog_on: assert property (@(posedge ref_clk) disable iff (rst)
        arrayMode[MB_WDOG] && modeReg[4][MM_CMP] |=> watchdogOn)
        else $error("watchdog enable not shown");
    a_module_irq: assert property (@(posedge ref_clk) disable iff (rst)
        arrayCtrl[1] && modeReg[1][MM_IE] |=> arrayIrq)
        else $error("module interrupt missing");
endmodule

/* shared/counter_array_pkg.sv */
package counter_array_pkg;
    localparam int NMOD = 5;
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_MODE = 5'h00;
    localparam logic [4:0] ADDR_CTRL = 5'h01;
    localparam logic [4:0] ADDR_CNT_LO = 5'h02;
    localparam logic [4:0] ADDR_CNT_HI = 5'h03;
    localparam logic [4:0] ADDR_MMODE0 = 5'h08;
    localparam logic [4:0] ADDR_VAL_LO0 = 5'h10;
    localparam logic [4:0] ADDR_VAL_HI0 = 5'h18;
    localparam int PIN_BASE = 3;
    localparam int EXT_PIN = 2;
    // field positions
    localparam int MB_IDLE = 7;
    localparam int MB_WDOG = 6;
    localparam int MB_SRC = 1;
    localparam int MB_OVIE = 0;
    localparam int CB_OVF = 7;
    localparam int CB_RUN = 6;
    localparam int MM_IE = 0;
    localparam int MM_PWM = 1;
    localparam int MM_FLIP = 2;
    localparam int MM_HIT = 3;
    localparam int MM_FALL = 4;
    localparam int MM_RISE = 5;
    localparam int MM_CMP = 6;
    // writable masks, reserved bits read zero
    localparam logic [7:0] MODE_MASK = 8'hc7;
    localparam logic [7:0] CTRL_MASK = 8'hdf;
    localparam logic [7:0] MMODE_MASK = 8'h7f;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] DIV12 = 4'hb;
    localparam logic [3:0] DIV4 = 4'h3;
    typedef enum logic [1:0] {
        SRC_DIV12 = 2'b00,
        SRC_DIV4 = 2'b01,
        SRC_T0 = 2'b10,
        SRC_EXT = 2'b11
    } count_src_e;
endpackage

/* core/count_source.sv */
module count_source (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // selection
    input wire logic [1:0] srcSel,
    input wire logic run,
    input wire logic timer0Ovf,
    input wire logic extIn,
    // event
    output logic tick
);
    import counter_array_pkg::*;

    logic [3:0] div;
    logic extQ;
    logic divHit;
    logic extRise;

    assign divHit = (srcSel == SRC_DIV4) ? (div >= DIV4) : (div >= DIV12);
    // inputs are synchronous; one register finds the edge.
    // a source above clock/8 is outside the contract and may lose counts
    assign extRise = extIn && !extQ;

    always_ff @(posedge ref_clk) begin
        if (rst || !run || divHit) begin
            div <= 4'h0;
        end else begin
            div <= div + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            extQ <= 1'b0;
        end else begin
            extQ <= extIn;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            case (count_src_e'(srcSel))
                SRC_DIV12: tick <= run && divHit;
                SRC_DIV4: tick <= run && divHit;
                SRC_T0: tick <= run && timer0Ovf;
                SRC_EXT: tick <= run && extRise;
                default: tick <= 1'b0;
            endcase
        end
    end
endmodule

/* core/module_value_mem.sv */
module module_value_mem #(
    parameter int DEPTH = 5
) (
    // clock
    input wire logic ref_clk,
    // port a: write
    input wire logic wrEn,
    input wire logic [2:0] wrIdx,
    input wire logic [15:0] wrData,
    // port b: registered read
    input wire logic [2:0] rdIdx,
    output logic [15:0] rdData
);
    logic [15:0] mem [DEPTH];

    // a three-bit index reaches eight words at most
    if (DEPTH < 1 || DEPTH > 8) begin
        $error("module_value_mem depth out of range");
    end

    always_ff @(posedge ref_clk) begin
        if (wrEn && int'(wrIdx) < DEPTH) begin
            mem[wrIdx] <= wrData;
        end
    end

    always_ff @(posedge ref_clk) begin
        rdData <= (int'(rdIdx) < DEPTH) ? mem[rdIdx] : 16'h0000;
    end
endmodule

/* test/port1_model.sv */
module port1_model (
    // clock
    input wire logic ref_clk,
    // control from the bench
    input wire logic extRun,
    input wire logic [4:0] pinDrive,
    // port 1
    input wire logic [7:0] port1Out,
    output logic [7:0] port1In
);
    timeunit 1ns;
    timeprecision 1ps;
    logic extLvl = 1'b0;
    int extCnt = 0;
    // a toggle every 8 cycles keeps the count input at clock/16 at most
    always @(posedge ref_clk) begin
        if (extRun) begin
            extCnt <= (extCnt == 7) ? 0 : extCnt + 1;
            if (extCnt == 7) extLvl <= ~extLvl;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // pull-up port: a pin is low if either side pulls it down
    assign port1In[1:0] = 2'b11;
    assign port1In[2] = extLvl;
    assign port1In[7:3] = port1Out[7:3] & pinDrive;
endmodule

/* test/programmable_counter_array_tb.sv */
module programmable_counter_array_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import counter_array_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic idle = 1'b0;
    logic timer0Ovf = 1'b0;
    logic [7:0] port1In;
    logic [7:0] port1Out;
    logic arrayIrq;
    logic watchdogOn;
    logic extRun = 1'b0;
    logic t0Run = 1'b0;
    logic [4:0] pinDrive = 5'h1f;
    int t0Cnt = 0;
    int failures = 0;
    int tests_run = 0;
    logic [7:0] d;
    logic [15:0] v;
    counter_array dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .idle(idle), .timer0Ovf(timer0Ovf),
        .port1In(port1In), .port1Out(port1Out), .arrayIrq(arrayIrq),
        .watchdogOn(watchdogOn));
    port1_model far_u (.ref_clk(ref_clk), .extRun(extRun),
        .pinDrive(pinDrive), .port1Out(port1Out), .port1In(port1In));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // timer 0 overflow pulses every 10 cycles
    always @(posedge ref_clk) begin
        t0Cnt <= (t0Cnt == 9) ? 0 : t0Cnt + 1;
        timer0Ovf <= t0Run && (t0Cnt == 9);
    end
    ////////////////////////////////////////////////////////////////////////
    // every task starts and ends just after a rising edge
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task wr(input logic [4:0] a, input logic [7:0] w);
        regAddr <= a;
        regWrData <= w;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task rd(input logic [4:0] a, output logic [7:0] r);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        r = regRdData;
    endtask
    task rd16(input logic [4:0] a, input logic [4:0] step,
        output logic [15:0] r);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a + step, hi);
        r = {hi, lo};
    endtask
    task setcnt(input logic [15:0] c);
        wr(ADDR_CNT_LO, c[7:0]);
        wr(ADDR_CNT_HI, c[15:8]);
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] inr(logic [15:0] x, int lo, int hi);
        return {15'h0, (x >= lo) && (x <= hi)};
    endfunction
    task summarize;
        $display("checks=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        logic [4:0] ra [5];
        ra = '{ADDR_MODE, ADDR_CTRL, ADDR_CNT_LO, ADDR_MMODE0, ADDR_VAL_HI0};
        check({8'h0, port1Out}, 16'h00ff);
        check({arrayIrq, watchdogOn}, 16'h0000);
        foreach (ra[i]) begin
            rd(ra[i], d);
            check({8'h0, d}, 16'h0000);
        end
    endtask
    task t_sources;
        int per [4];
        logic [15:0] held;
        per = '{12, 4, 10, 16};
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_MODE, {5'h0, 2'(s), 1'b0});
            setcnt(16'h0000);
            t0Run <= (s == 2);
            extRun <= (s == 3);
            wr(ADDR_CTRL, 8'h40);
            cyc(100 * per[s]);
            wr(ADDR_CTRL, 8'h00);
            rd16(ADDR_CNT_LO, 5'h01, v);
            check(inr(v, 96, 102), 16'h0001);
            held = v;
            cyc(20);
            rd16(ADDR_CNT_LO, 5'h01, v);
            check(v, held);
        end
        t0Run <= 1'b0;
        extRun <= 1'b0;
    endtask
    task t_overflow;
        wr(ADDR_MODE, 8'h03);
        setcnt(16'hfff0);
        wr(ADDR_CTRL, 8'h40);
        cyc(120);
        rd(ADDR_CTRL, d);
        check({8'h0, d}, 16'h00c0);
        check({15'h0, arrayIrq}, 16'h0001);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, d);
        check({7'h0, arrayIrq, d}, 16'h0000);
        wr(ADDR_CTRL, 8'h80);
        rd(ADDR_CTRL, d);
        check({7'h0, arrayIrq, d}, 16'h0180);
        wr(ADDR_MODE, 8'h02);
        cyc(2);
        check({15'h0, arrayIrq}, 16'h0000);
        wr(ADDR_CTRL, 8'h00);
    endtask
    task t_hit;
        wr(ADDR_VAL_LO0 + 5'd1, 8'h20);
        wr(ADDR_VAL_HI0 + 5'd1, 8'h00);
        wr(ADDR_MMODE0 + 5'd1, 8'h4d);
        setcnt(16'h0000);
        wr(ADDR_CTRL, 8'h40);
        cyc(200);
        rd(ADDR_CTRL, d);
        check({8'h0, d}, 16'h0042);
        check({port1Out[4], arrayIrq}, 16'h0001);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, d);
        check({7'h0, arrayIrq, d}, 16'h0000);
        wr(ADDR_MMODE0 + 5'd1, 8'h00);
    endtask
    task t_capture;
        wr(ADDR_MMODE0 + 5'd3, 8'h20);
        setcnt(16'h1234);
        pinDrive[3] <= 1'b0;
        cyc(6);
        rd(ADDR_CTRL, d);
        check({8'h0, d}, 16'h0000);
        pinDrive[3] <= 1'b1;
        cyc(6);
        rd(ADDR_CTRL, d);
        check({8'h0, d}, 16'h0008);
        rd16(ADDR_VAL_LO0 + 5'd3, 5'h08, v);
        check(v, 16'h1234);
        check({15'h0, arrayIrq}, 16'h0000);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MMODE0 + 5'd3, 8'h10);
        setcnt(16'h5678);
        pinDrive[3] <= 1'b0;
        cyc(6);
        rd16(ADDR_VAL_LO0 + 5'd3, 5'h08, v);
        check(v, 16'h5678);
        wr(ADDR_MMODE0 + 5'd3, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        pinDrive[3] <= 1'b1;
    endtask
    task t_pwm;
        int hi;
        hi = 0;
        wr(ADDR_VAL_LO0, 8'h00);
        wr(ADDR_VAL_HI0, 8'hc0);
        wr(ADDR_MMODE0, 8'h42);
        setcnt(16'h0000);
        wr(ADDR_CTRL, 8'h40);
        cyc(1100);
        rd(ADDR_VAL_LO0, d);
        check({8'h0, d}, 16'h00c0);
        for (int i = 0; i < 2048; i++) begin
            cyc(1);
            hi += port1Out[3];
        end
        // low byte at or above 0xc0 for 64 of every 256 steps
        check(inr(16'(hi), 496, 528), 16'h0001);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MMODE0, 8'h00);
    endtask
    task t_idle;
        wr(ADDR_MODE, 8'h82);
        setcnt(16'h0000);
        idle <= 1'b1;
        wr(ADDR_CTRL, 8'h40);
        cyc(200);
        rd16(ADDR_CNT_LO, 5'h01, v);
        check(v, 16'h0000);
        wr(ADDR_MODE, 8'h02);
        cyc(200);
        wr(ADDR_CTRL, 8'h00);
        rd16(ADDR_CNT_LO, 5'h01, v);
        check(inr(v, 46, 54), 16'h0001);
        idle <= 1'b0;
    endtask
    task t_regs;
        wr(ADDR_MODE, 8'h40);
        wr(ADDR_MMODE0 + 5'd4, 8'h48);
        cyc(2);
        check({15'h0, watchdogOn}, 16'h0001);
        wr(ADDR_MODE, 8'h00);
        cyc(2);
        check({15'h0, watchdogOn}, 16'h0000);
        wr(ADDR_MMODE0 + 5'd4, 8'hff);
        rd(ADDR_MMODE0 + 5'd4, d);
        check({8'h0, d}, 16'h007f);
        wr(ADDR_MMODE0 + 5'd4, 8'h00);
        wr(ADDR_CTRL, 8'h20);
        rd(ADDR_CTRL, d);
        check({8'h0, d}, 16'h0000);
        wr(5'h1f, 8'h5a);
        rd(5'h1f, d);
        check({8'h0, d}, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_sources();
        t_overflow();
        t_hit();
        t_capture();
        t_pwm();
        t_idle();
        t_regs();
        summarize();
    end
    // the tests take about 8300 cycles
    initial begin
        #500000;
        failures++;
        summarize();
    end
endmodule
